// [twsp_timer.sv]
// What this block does
// - Clock source select zero: count once per instruction cycle without prescaler.
// - After a count write, skip increments for the next two instruction cycles.
// - Clock source select one: count edges of the external count input.
// - Source edge select picks rising (zero) or falling (one) external edges.
// - Prescaler serves timer when assign bit zero, watchdog when one.
// - Timer prescale ratio spans 1:2 to 1:256 in powers of two.
// - One 8-bit counter, prescaler for timer or postscaler for watchdog.
// - Prescaler count can be neither read nor written by software.
// - Any count write clears the prescaler while it belongs to the timer.
// - Watchdog clear clears the prescaler while it belongs to the watchdog.
// - Reset forces the prescaler count to zero.
// - Prescaler output is sampled in phase two and phase four.
// - Count updates 4 to 6 oscillator periods after an input change.
// - Count register is 8-bit, readable and writable, kept over other resets.
`timescale 1ns/1ps
`default_nettype none
module twsp_timer
  import twsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic power_on_i,
  input wire twsp_wr_t count_wr_i,
  input wire twsp_wr_t cfg_wr_i,
  input wire logic portc_dir_wr_i,
  input wire logic [5:0] portc_dir_wdata_i,
  input wire logic watchdog_clear_op_i,
  input wire logic dog_timer_tick_i,
  input wire logic ext_count_input_i,
  output logic [7:0] timer_count_reg_o,
  output twsp_cfg_t cfg_o,
  output logic [5:0] portc_direction_o,
  output logic dog_timeout_o,
  output logic [1:0] phase_o
);

  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic instr_tick;
  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic pre_event;
  logic pre_carry;
  logic [7:0] pre_mask;
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic pending_q;
  logic pending_d;
  logic sample;
  logic inc_evt;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  twsp_cfg_t cfg_q;
  twsp_cfg_t cfg_d;
  logic [5:0] dir_q;
  logic [5:0] dir_d;
  logic dog_out_q;
  logic dog_out_d;

  // Division mask: timer divides by twice the watchdog ratio
  function automatic logic [7:0] ratio_mask(input logic [2:0] ps, input logic to_dog);
    logic [8:0] m;
    m = 9'h000;
    if (to_dog)
    begin
      m = (9'h001 << ps) - 9'h001;
    end
    else
    begin
      m = (9'h002 << ps) - 9'h001;
    end
    return m[7:0];
  endfunction : ratio_mask

  twsp_pin_sync u_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .pin_i(ext_count_input_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  // Phase counter, one oscillator period per phase
  always_comb
  begin
    phase_d = phase_q + 2'h1;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phase_q <= PHASE_ONE;
    end
    else
    begin
      phase_q <= phase_d;
    end
  end

  assign instr_tick = (phase_q == PHASE_FOUR);
  assign sample = (phase_q == PHASE_TWO) || (phase_q == PHASE_FOUR);
  assign ext_edge = cfg_q.source_edge_select ? ext_fall : ext_rise;

  // Prescaler input: timer source when assigned there, else watchdog ticks
  always_comb
  begin
    if (cfg_q.prescaler_assign)
    begin
      pre_event = dog_timer_tick_i;
    end
    else if (cfg_q.clock_source_select)
    begin
      pre_event = ext_edge;
    end
    else
    begin
      pre_event = instr_tick;
    end
  end

  assign pre_mask = ratio_mask(cfg_q.prescale_ratio, cfg_q.prescaler_assign);
  assign pre_carry = pre_event && ((pre_q & pre_mask) == pre_mask);

  // Prescaler count: no read path exists, clears only as below
  always_comb
  begin
    pre_d = pre_q;
    if (pre_event)
    begin
      pre_d = pre_q + 8'h01;
    end
    if (count_wr_i.wr && !cfg_q.prescaler_assign)
    begin
      pre_d = 8'h00;
    end
    if (watchdog_clear_op_i && cfg_q.prescaler_assign)
    begin
      pre_d = 8'h00;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pre_q <= 8'h00;
    end
    else
    begin
      pre_q <= pre_d;
    end
  end

  // Watchdog postscaler output pulse, one cycle
  always_comb
  begin
    dog_out_d = cfg_q.prescaler_assign && pre_carry;
  end

  // Timer increments: internal ticks go straight, external ones wait for a sample
  always_comb
  begin
    pending_d = pending_q;
    inc_evt = 1'b0;
    // Internal source: with the prescaler on the dog, count every instruction tick
    if (!cfg_q.clock_source_select)
    begin
      pending_d = 1'b0;
      inc_evt = cfg_q.prescaler_assign ? instr_tick : pre_carry;
    end
    else
    begin
      if (sample)
      begin
        inc_evt = pending_q;
        pending_d = 1'b0;
      end
      // An edge landing on a sample slot is kept, not lost
      if (!cfg_q.prescaler_assign && pre_carry)
      begin
        pending_d = 1'b1;
      end
      else if (cfg_q.prescaler_assign && cfg_q.clock_source_select && ext_edge)
      begin
        pending_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pending_q <= 1'b0;
      dog_out_q <= 1'b0;
    end
    else
    begin
      pending_q <= pending_d;
      dog_out_q <= dog_out_d;
    end
  end

  // Count register, write hold-off and wrap
  always_comb
  begin
    count_d = count_q;
    hold_d = hold_q;
    if (count_wr_i.wr)
    begin
      count_d = count_wr_i.data;
      hold_d = WRITE_HOLDOFF;
    end
    else
    begin
      if (inc_evt && hold_q == 2'h0)
      begin
        count_d = count_q + 8'h01;
      end
      if (instr_tick && hold_q != 2'h0)
      begin
        hold_d = hold_q - 2'h1;
      end
    end
  end

  // Count survives warm resets; only a power-on clears it to a known value
  always_ff @(posedge mclk_i)
  begin
    if (power_on_i)
    begin
      count_q <= COUNT_RESET;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hold_q <= 2'h0;
    end
    else
    begin
      hold_q <= hold_d;
    end
  end

  // Write-only configuration and port direction registers
  always_comb
  begin
    cfg_d = cfg_wr_i.wr ? twsp_cfg_t'(cfg_wr_i.data) : cfg_q;
    dir_d = portc_dir_wr_i ? portc_dir_wdata_i : dir_q;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q <= twsp_cfg_t'(CFG_RESET);
      dir_q <= PORTC_DIR_RESET;
    end
    else
    begin
      cfg_q <= cfg_d;
      dir_q <= dir_d;
    end
  end

  assign timer_count_reg_o = count_q;
  assign cfg_o = cfg_q;
  assign portc_direction_o = dir_q;
  assign dog_timeout_o = dog_out_q;
  assign phase_o = phase_q;

endmodule : twsp_timer
`default_nettype wire

// [twsp_pkg.sv]
package twsp_pkg;

  // Phase clock: four oscillator periods (one per mclk) per instruction
  localparam logic [1:0] PHASE_ONE = 2'h0;
  localparam logic [1:0] PHASE_TWO = 2'h1;
  localparam logic [1:0] PHASE_FOUR = 2'h3;

  // Register file address of the count register
  localparam logic [4:0] TIMER_COUNT_ADDR = 5'h01;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'hFF;
  localparam logic [5:0] PORTC_DIR_RESET = 6'h3F;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // Instruction cycles without increment after a count write
  localparam logic [1:0] WRITE_HOLDOFF = 2'h2;

  // Timing configuration register layout, bit 7 down to bit 0
  typedef struct packed {
    logic wake_on_change_disable;
    logic weak_pullup_disable;
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_ratio;
  } twsp_cfg_t;

  // One CPU write to the count or configuration register
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } twsp_wr_t;

endpackage : twsp_pkg

// [twsp_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser for the external count pin, with edge pulses
module twsp_pin_sync
  import twsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  logic level_d;

  // A change counts only once stages two and three agree
  always_comb
  begin
    level_d = level_q;
    if (s2_q == s3_q)
    begin
      level_d = s3_q;
    end
  end

  // First stage is read by the second only, against metastability
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign rise_o = level_d & ~level_q;
  assign fall_o = ~level_d & level_q;

endmodule : twsp_pin_sync
`default_nettype wire

// [twsp_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module twsp_timer_checker
  import twsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic power_on_i,
  input wire twsp_wr_t count_wr_i,
  input wire logic dog_timer_tick_i,
  input wire logic [7:0] timer_count_reg_o,
  input wire twsp_cfg_t cfg_o,
  input wire logic [5:0] portc_direction_o,
  input wire logic dog_timeout_o,
  input wire logic [1:0] phase_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Count sits still for four cycles, through the first skipped tick
  sequence s_hold;
    $stable(timer_count_reg_o)[*4];
  endsequence
  // Count moved with no load behind it
  sequence s_step;
    $changed(timer_count_reg_o) && !$past(count_wr_i.wr) && !$past(power_on_i);
  endsequence
  load_a:
    assert property (count_wr_i.wr && !power_on_i |=> timer_count_reg_o == $past(count_wr_i.data))
    else $error("load lost");
  holdoff_a:
    assert property (count_wr_i.wr && !cfg_o.clock_source_select |=> ##1 s_hold)
    else $error("holdoff broken");
  step_one_a:
    assert property (s_step |-> timer_count_reg_o == $past(timer_count_reg_o) + 8'h01
      && $past(phase_o[0]))
    else $error("bad step");
  int_tick_a:
    assert property (s_step ##0 !$past(cfg_o.clock_source_select) |-> $past(phase_o) == PHASE_FOUR)
    else $error("tick off phase");
  phase_walk_a:
    assert property ($past(rst_n_i) |-> phase_o == $past(phase_o) + 2'h1)
    else $error("phase skip");
  dog_pass_a:
    assert property (dog_timer_tick_i && cfg_o.prescaler_assign && cfg_o.prescale_ratio == 3'h0
      |=> dog_timeout_o)
    else $error("dog tick lost");
  dog_owner_a:
    assert property (dog_timeout_o |-> $past(dog_timer_tick_i && cfg_o.prescaler_assign))
    else $error("stray dog pulse");
  reset_vals_a:
    assert property ($rose(rst_n_i) |-> cfg_o == CFG_RESET && portc_direction_o == PORTC_DIR_RESET)
    else $error("reset values");
endmodule : twsp_timer_checker

bind twsp_timer twsp_timer_checker i_twsp_timer_checker (.mclk_i, .rst_n_i, .power_on_i,
  .count_wr_i, .dog_timer_tick_i, .timer_count_reg_o, .cfg_o, .portc_direction_o,
  .dog_timeout_o, .phase_o);
`default_nettype wire

// [twsp_ext_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Count pin source; the pin idles low outside bursts
module twsp_ext_src (
  input wire logic mclk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Each level held 6 mclk, well over the minimum high and low time
  task automatic drive(input logic lvl);
    @(posedge mclk_i);
    #1 pin_o = lvl;
    repeat (6) @(posedge mclk_i);
  endtask : drive
endmodule : twsp_ext_src
`default_nettype wire

// [twsp_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module twsp_timer_tb
  import twsp_pkg::*;
;
  logic mclk_i, rst_n_i, power_on_i, pdir_wr, wclr, tick, pin, dto;
  logic [7:0] cnt;
  logic [5:0] pdir;
  twsp_wr_t cnt_wr, cfg_wr;
  twsp_cfg_t cfg;
  int n_fail, n_checks, n_dto;
  twsp_timer i_twsp_timer (.mclk_i, .rst_n_i, .power_on_i, .count_wr_i(cnt_wr),
    .cfg_wr_i(cfg_wr), .portc_dir_wr_i(pdir_wr), .portc_dir_wdata_i(6'h15),
    .watchdog_clear_op_i(wclr), .dog_timer_tick_i(tick), .ext_count_input_i(pin),
    .timer_count_reg_o(cnt), .cfg_o(cfg), .portc_direction_o(pdir), .dog_timeout_o(dto),
    .phase_o());
  twsp_ext_src i_twsp_ext_src (.mclk_i, .pin_o(pin));
  // 125 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // Timeout pulses last one cycle, so tally them as they pass
  always @(posedge mclk_i) if (dto === 1'b1) n_dto++;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  // One CPU action: 0 count write, 1 config write, 2 dog clear, 3 dog tick
  task automatic op(input int k, input logic [7:0] d = 8'h00);
    case (k)
      0: cnt_wr = {1'b1, d};
      1: cfg_wr = {1'b1, d};
      2: wclr = 1'b1;
      default: tick = 1'b1;
    endcase
    cyc(1);
    {cnt_wr.wr, cfg_wr.wr, wclr, tick} = 4'h0;
    cyc(1);
  endtask : op
  // Cycles until the count moves, bounded so a stuck count cannot hang
  task automatic nxt(output int g);
    logic [7:0] v;
    v = cnt;
    g = 0;
    while (cnt === v && g < 3000)
    begin
      cyc(1);
      g++;
    end
  endtask : nxt
  // f: index of the first instruction tick after the write that may step the count
  task automatic t_gap(input logic [7:0] c, input int e, input int f);
    int g;
    op(2);
    op(1, c);
    op(0, 8'hFE);
    nxt(g);
    `CHK("first step", 8'hFF, cnt)
    `CHK("first gap", 1'b1, (g >= 4 * f - 4) && (g <= 4 * f - 1))
    nxt(g);
    `CHK("wrap", 8'h00, cnt)
    `CHK("period", e, g)
    $display("rate %h done", c);
  endtask : t_gap
  task automatic t_ext(input logic [7:0] c, input int n, input logic [7:0] hi, e);
    op(2);
    op(1, c);
    op(0);
    cyc(8);
    i_twsp_ext_src.drive(1'b1);
    cyc(1);
    `CHK("after rise", hi, cnt)
    i_twsp_ext_src.drive(1'b0);
    repeat (n - 1)
    begin
      i_twsp_ext_src.drive(1'b1);
      i_twsp_ext_src.drive(1'b0);
    end
    cyc(8);
    `CHK("edge total", e, cnt)
    $display("pin count %h done", c);
  endtask : t_ext
  // Move prescaler to the dog the safe way, then probe its ratios
  task automatic t_dog;
    op(2);
    op(0);
    op(1, 8'h0F);
    op(2);
    op(1, 8'h09);
    n_dto = 0;
    op(3);
    op(2);
    op(3);
    `CHK("dog clear", 0, n_dto)
    op(3);
    `CHK("dog 1:2", 1, n_dto)
    op(1, 8'h08);
    op(3);
    op(3);
    `CHK("dog 1:1", 3, n_dto)
    op(2);
    op(1, 8'h00);
    op(3);
    `CHK("timer owns", 3, n_dto)
    $display("dog done");
  endtask : t_dog
  // Count must ride through a reset that restores config
  task automatic t_rst;
    op(1, 8'h28);
    op(0, 8'h5A);
    rst_n_i = 1'b0;
    cyc(2);
    rst_n_i = 1'b1;
    cyc(1);
    `CHK("count kept", 8'h5A, cnt)
    `CHK("config", CFG_RESET, cfg)
    $display("reset done");
  endtask : t_rst
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial
  begin
    rst_n_i = 1'b0;
    {power_on_i, pdir_wr, wclr, tick} = 4'h0;
    cnt_wr = '0;
    cfg_wr = '0;
    cyc(2);
    rst_n_i = 1'b1;
    `CHK("config", CFG_RESET, cfg)
    `CHK("direction", PORTC_DIR_RESET, pdir)
    {power_on_i, pdir_wr} = 2'h3;
    cyc(1);
    {power_on_i, pdir_wr} = 2'h0;
    cyc(1);
    `CHK("power on", COUNT_RESET, cnt)
    `CHK("direction wr", 6'h15, pdir)
    t_gap(8'h08, 4, 3);
    for (int p = 0; p < 8; p++)
      t_gap(8'(p), 8 << p, (p == 0) ? 4 : 2 << p);
    t_ext(8'h28, 1, 8'h01, 8'h01);
    t_ext(8'h38, 1, 8'h00, 8'h01);
    t_ext(8'h20, 4, 8'h00, 8'h02);
    t_dog();
    t_rst();
    wrap_up();
  end
  // Hang guard, far beyond the slowest rate sweep
  initial
  begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule : twsp_timer_tb
`default_nettype wire
